//--- hw/spc_serdes_regs.sv
// Serial port PCS control and status register bank with link qualification
//
// Local design decision: the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none

module spc_serdes_regs #(
    parameter int unsigned STABLE_CYCLES = spc_pkg::STABLE_CYCLES  // Sync hold time
) (
    // Clock and reset
    input  wire logic                  i_core_clk,
    input  wire logic                  i_srst,
    // AHB-Lite slave
    input  wire logic                  hsel,
    input  wire logic [31:0]           haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [31:0]           hwdata,
    input  wire logic                  hready,
    output logic      [31:0]           hrdata,
    output logic                       hreadyout,
    output logic                       hresp,
    // Port mode and negotiation
    input  wire logic                  i_sgmii_mode,
    input  wire logic                  i_an_enable,
    input  wire logic                  i_an_done,
    input  wire logic                  i_half_duplex,
    input  wire logic                  i_crc_check_off,
    // Receive line conditions
    input  wire logic                  i_sync_ok,
    input  wire logic                  i_rx_idle,
    input  wire logic                  i_rx_code_word,
    input  wire logic                  i_remote_fault_cond,
    // Carrier sources
    input  wire logic                  i_tx_active,
    input  wire logic                  i_rx_active,
    // Event pulses and resolved results
    input  wire spc_pkg::spc_events_t  i_events,
    input  wire spc_pkg::spc_resolved_t i_resolved,
    // Link outputs
    output logic                       o_link_up,
    output logic                       o_an_active,
    output logic                       o_remote_fault_tx,
    output logic                       o_carrier_sense,
    output logic      [1:0]            o_elastic_buffer_depth,
    output logic      [13:0]           o_elastic_limit
);

    localparam int unsigned CW = $clog2(STABLE_CYCLES + 1);  // Timer width

    // Registered control fields
    logic        remote_fault_sense_off;  // Control 2 bit 4
    logic        stable_filter_on;        // Control 2 bit 2
    logic        premature_link_block;    // Control 2 bit 1
    logic        parallel_detect_on;      // Control 2 bit 0
    logic        tx_carrier_sense_off;    // Control 3 bit 13
    logic [1:0]  elastic_buffer_depth;    // Control 3 bits 2:1

    // Latched status
    spc_pkg::spc_events_t ev_latched;     // Bits 15:8
    logic        link_toggled;            // Bit 7

    // Data phase bookkeeping
    logic        dp_write;                // Write pending in data phase
    logic [7:0]  dp_index;                // Its register index

    // Link machinery
    spc_pkg::spc_link_state_t link_state;
    logic [CW-1:0] stable_cnt;            // Sync hold counter
    logic        link_blocked;            // Code words seen with AN off
    logic        pd_an_on;                // Parallel detect decision

    // Address phase decode
    // Size is not decoded; every access is taken as a whole word
    wire         addr_phase = hsel && hready && htrans[1];
    wire         aligned    = (haddr[1:0] == 2'h0) && (haddr[31:10] == 22'h0);
    wire [7:0]   a_index    = haddr[9:2];
    wire         rd_req     = addr_phase && !hwrite && aligned;
    wire         wr_req     = addr_phase && hwrite && aligned;
    wire         rd_stat    = rd_req && (a_index == spc_pkg::IDX_STAT1);

    // Data phase write strobes
    wire         wr_ctrl2   = dp_write && (dp_index == spc_pkg::IDX_CTRL2);
    wire         wr_ctrl3   = dp_write && (dp_index == spc_pkg::IDX_CTRL3);

    // Readback images
    wire [15:0]  ctrl2_img  = {11'h000, remote_fault_sense_off, 1'b0, stable_filter_on,
                               premature_link_block, parallel_detect_on};
    // Bit 6 reads back one; the other reserved bits read zero
    wire [15:0]  ctrl3_img  = {2'h0, tx_carrier_sense_off, 6'h00, 1'b1, 3'h0,
                               elastic_buffer_depth, 1'b0};
    // Live part of status: pause, speed, duplex, link, mode
    wire [15:0]  stat_img   = {ev_latched, link_toggled, i_resolved, o_link_up,
                               i_sgmii_mode};

    // Read mux; reserved word and unmapped addresses read zero
    // Only a status read has a side effect, the clear of the latched bits
    wire [15:0]  rd_mux     = (a_index == spc_pkg::IDX_CTRL2) ? ctrl2_img :
                              (a_index == spc_pkg::IDX_CTRL3) ? ctrl3_img :
                              (a_index == spc_pkg::IDX_STAT1) ? stat_img  : 16'h0000;

    // Incoming events; checksum events ignored while detection is off
    spc_pkg::spc_events_t ev_in;
    always_comb
    begin
        ev_in           = i_events;
        ev_in.crc_fault = i_events.crc_fault && !i_crc_check_off;
    end

    // Set wins over the read clear, so no event in the read cycle is lost
    spc_pkg::spc_events_t next_ev_latched;
    always_comb
    begin
        next_ev_latched = rd_stat ? '0 : ev_latched;
        next_ev_latched = next_ev_latched | ev_in;
        if (i_crc_check_off)
        begin
            next_ev_latched.crc_fault = 1'b0;
        end
    end

    // Parallel detect decision from what the partner sends
    wire         an_eff     = parallel_detect_on ? pd_an_on : i_an_enable;
    // Blocking only matters with AN off and no parallel detect
    wire         block_arm  = premature_link_block && !an_eff && !parallel_detect_on;
    // Code words in the arming cycle already refuse, so no one-cycle link glitch
    wire         cand_ok    = an_eff ? (i_sync_ok && i_an_done)
                                     : (i_sync_ok && !link_blocked
                                        && !(block_arm && i_rx_code_word));
    wire         use_filter = stable_filter_on && !an_eff;
    // Entry edge counts as the first step of the wait, hence one short
    wire         timer_done = (stable_cnt == CW'(STABLE_CYCLES - 1));

    // Link state transitions
    spc_pkg::spc_link_state_t next_link_state;
    always_comb
    begin
        case (link_state)
            spc_pkg::LINK_DOWN:
            begin
                if (!cand_ok)
                    next_link_state = spc_pkg::LINK_DOWN;
                else if (use_filter)
                    next_link_state = spc_pkg::LINK_QUALIFY;
                else
                    next_link_state = spc_pkg::LINK_UP;
            end
            spc_pkg::LINK_QUALIFY:
            begin
                // Any dropout restarts the wait from scratch
                if (!cand_ok || !use_filter)
                    next_link_state = spc_pkg::LINK_DOWN;
                else if (timer_done)
                    next_link_state = spc_pkg::LINK_UP;
                else
                    next_link_state = spc_pkg::LINK_QUALIFY;
            end
            spc_pkg::LINK_UP:
            begin
                next_link_state = cand_ok ? spc_pkg::LINK_UP : spc_pkg::LINK_DOWN;
            end
            default:
            begin
                next_link_state = spc_pkg::LINK_DOWN;
            end
        endcase
    end

    wire         next_link  = (next_link_state == spc_pkg::LINK_UP);

    // Depth code to packet limit; upper code bit alone picks the largest
    wire [13:0]  next_limit = elastic_buffer_depth[1] ? spc_pkg::LIMIT_13K5 :
                              (elastic_buffer_depth == spc_pkg::DEPTH_10K) ?
                              spc_pkg::LIMIT_10K : spc_pkg::LIMIT_5K;

    // Carrier sense; transmit contribution dropped in half duplex when off
    wire         tx_crs     = i_tx_active && !(tx_carrier_sense_off && i_half_duplex);
    wire         next_crs   = i_rx_active || tx_crs;

    // Remote fault report in fiber mode only
    wire         next_rf    = !i_sgmii_mode && !remote_fault_sense_off
                              && i_remote_fault_cond;

    // Bus response flops; zero wait states, always OKAY
    // Read data drops to zero after its data phase so stale words never linger
    always_ff @(posedge i_core_clk)
    begin
        if (i_srst)
        begin
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b0;
            hresp     <= 1'b0;
            dp_write  <= 1'b0;
            dp_index  <= 8'h00;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            hrdata    <= rd_req ? {16'h0000, rd_mux} : 32'h0000_0000;
            dp_write  <= wr_req;
            dp_index  <= a_index;
        end
    end

    // Control 2 writes; reserved bits drop whatever software sends
    always_ff @(posedge i_core_clk)
    begin
        if (i_srst)
        begin
            remote_fault_sense_off <= spc_pkg::C2_RESET[spc_pkg::C2_RF_OFF];
            stable_filter_on       <= spc_pkg::C2_RESET[spc_pkg::C2_STABLE];
            premature_link_block   <= spc_pkg::C2_RESET[spc_pkg::C2_BLOCK];
            parallel_detect_on     <= spc_pkg::C2_RESET[spc_pkg::C2_PAR_DET];
        end
        else if (wr_ctrl2)
        begin
            remote_fault_sense_off <= hwdata[spc_pkg::C2_RF_OFF];
            stable_filter_on       <= hwdata[spc_pkg::C2_STABLE];
            premature_link_block   <= hwdata[spc_pkg::C2_BLOCK];
            parallel_detect_on     <= hwdata[spc_pkg::C2_PAR_DET];
        end
    end

    // Control 3 writes; bit 6 is fixed high in the readback only
    always_ff @(posedge i_core_clk)
    begin
        if (i_srst)
        begin
            tx_carrier_sense_off <= spc_pkg::C3_RESET[spc_pkg::C3_TXCRS_OFF];
            elastic_buffer_depth <= spc_pkg::C3_RESET[spc_pkg::C3_DEPTH_LO +: 2];
        end
        else if (wr_ctrl3)
        begin
            tx_carrier_sense_off <= hwdata[spc_pkg::C3_TXCRS_OFF];
            elastic_buffer_depth <= hwdata[spc_pkg::C3_DEPTH_LO +: 2];
        end
    end

    // Latched status bits
    always_ff @(posedge i_core_clk)
    begin
        if (i_srst)
        begin
            ev_latched   <= '0;
            link_toggled <= 1'b0;
        end
        else
        begin
            ev_latched   <= next_ev_latched;
            // Change seen in the read cycle still latches
            link_toggled <= (link_toggled && !rd_stat) || (next_link != o_link_up);
        end
    end

    // Parallel detect and premature link blocking
    always_ff @(posedge i_core_clk)
    begin
        if (i_srst)
        begin
            pd_an_on     <= 1'b1;
            link_blocked <= 1'b0;
        end
        else
        begin
            // Code words mean the partner negotiates; idles mean it does not
            // A code word wins when both arrive in one cycle
            if (i_rx_code_word)
                pd_an_on <= 1'b1;
            else if (i_rx_idle)
                pd_an_on <= 1'b0;
            // Idles release the block, code words arm it
            if (!block_arm || i_rx_idle)
                link_blocked <= 1'b0;
            else if (i_rx_code_word)
                link_blocked <= 1'b1;
        end
    end

    // Link state and hold timer
    always_ff @(posedge i_core_clk)
    begin
        if (i_srst)
        begin
            link_state <= spc_pkg::LINK_DOWN;
            stable_cnt <= '0;
        end
        else
        begin
            link_state <= next_link_state;
            stable_cnt <= (next_link_state == spc_pkg::LINK_QUALIFY &&
                           link_state == spc_pkg::LINK_QUALIFY) ?
                          CW'(stable_cnt + 1'b1) : '0;
        end
    end

    // Registered port outputs
    // Depth and limit move together, one cycle after the control write lands
    always_ff @(posedge i_core_clk)
    begin
        if (i_srst)
        begin
            o_link_up              <= 1'b0;
            o_an_active            <= 1'b0;
            o_remote_fault_tx      <= 1'b0;
            o_carrier_sense        <= 1'b0;
            o_elastic_buffer_depth <= spc_pkg::DEPTH_10K;
            o_elastic_limit        <= spc_pkg::LIMIT_10K;
        end
        else
        begin
            o_link_up              <= next_link;
            o_an_active            <= an_eff;
            o_remote_fault_tx      <= next_rf;
            o_carrier_sense        <= next_crs;
            o_elastic_buffer_depth <= elastic_buffer_depth;
            o_elastic_limit        <= next_limit;
        end
    end

endmodule : spc_serdes_regs

`default_nettype wire

//--- hw/spc_pkg.sv
// Package: offsets, fields, resets and types of the serial port PCS registers
package spc_pkg;

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_CTRL2 = 8'h22;
    localparam logic [7:0] IDX_CTRL3 = 8'h24;
    localparam logic [7:0] IDX_RSVD  = 8'h26;
    localparam logic [7:0] IDX_STAT1 = 8'h28;
    localparam int unsigned ADDR_SHIFT = 2;

    // Control 2 fields
    localparam int unsigned C2_RF_OFF   = 4;
    localparam int unsigned C2_STABLE   = 2;
    localparam int unsigned C2_BLOCK    = 1;
    localparam int unsigned C2_PAR_DET  = 0;
    localparam logic [15:0] C2_WMASK    = 16'h0017;
    localparam logic [15:0] C2_RESET    = 16'h0001;

    // Control 3 fields
    localparam int unsigned C3_TXCRS_OFF = 13;
    localparam int unsigned C3_DEPTH_LO  = 1;
    localparam logic [15:0] C3_WMASK     = 16'h2006;
    localparam logic [15:0] C3_RESET     = 16'h0042;
    localparam logic [15:0] C3_RSVD_ONES = 16'h0040;

    // Elastic buffer depth codes and packet limits in bytes
    localparam logic [1:0]  DEPTH_5K   = 2'h0;
    localparam logic [1:0]  DEPTH_10K  = 2'h1;
    localparam logic [13:0] LIMIT_5K   = 14'h1400;
    localparam logic [13:0] LIMIT_10K  = 14'h2800;
    localparam logic [13:0] LIMIT_13K5 = 14'h3600;

    // Stable link qualification time
    localparam int unsigned STABLE_TIME_US = 10000;
    localparam int unsigned CLK_PERIOD_NS  = 100;
    localparam int unsigned STABLE_CYCLES  = STABLE_TIME_US * 1000 / CLK_PERIOD_NS;

    // AHB encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ    = 2'h3;

    // Latched event sources, in status bit order 15 down to 8
    typedef struct packed {
        logic tx_buffer_fault;
        logic rx_buffer_fault;
        logic bogus_carrier_seen;
        logic crc_fault;
        logic data_error;
        logic early_end;
        logic carrier_extend_fault;
        logic early_end_extend;
    } spc_events_t;

    // Resolved link parameters reported live
    typedef struct packed {
        logic       pause_rx_resolved;
        logic       pause_tx_resolved;
        logic [1:0] speed;
        logic       full_duplex;
    } spc_resolved_t;

    // Link qualification states
    typedef enum logic [1:0] {
        LINK_DOWN,
        LINK_QUALIFY,
        LINK_UP
    } spc_link_state_t;

endpackage : spc_pkg

//--- testbench/spc_serdes_regs_monitor.sv
// Port checker for the serial port PCS register bank
`timescale 1ns/1ps
`default_nettype none
module spc_serdes_regs_monitor #(
    parameter int unsigned STABLE_CYCLES = 20  // Qualification time, handed on by bind
) (
    // Clock and reset
    input wire logic                 i_core_clk,
    input wire logic                 i_srst,
    // Register bus
    input wire logic                 hsel,
    input wire logic [31:0]          haddr,
    input wire logic [1:0]           htrans,
    input wire logic                 hwrite,
    input wire logic                 hready,
    input wire logic [31:0]          hrdata,
    input wire logic                 hreadyout,
    input wire logic                 hresp,
    // Line side
    input wire logic                 i_sgmii_mode,
    input wire logic                 i_remote_fault_cond,
    input wire logic                 i_sync_ok,
    input wire logic                 i_tx_active,
    input wire logic                 i_rx_active,
    input wire spc_pkg::spc_events_t i_events,
    input wire logic                 o_link_up,
    input wire logic                 o_remote_fault_tx,
    input wire logic                 o_carrier_sense,
    input wire logic [1:0]           o_elastic_buffer_depth,
    input wire logic [13:0]          o_elastic_limit
);
    // One clock domain, so clock and reset are given once
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (i_srst);

    // Address phase of a status read
    sequence s_stat_rd;
        hsel && hready && htrans[1] && !hwrite && haddr == 32'h0000_00a0;
    endsequence

    a_bus_okay: assert property (hresp == 1'h0)
        else $error("bus response not okay");
    a_ready_up: assert property (!i_srst |=> hreadyout)
        else $error("ready low after reset");
    a_rf_sgmii: assert property (i_sgmii_mode |=> !o_remote_fault_tx)
        else $error("remote fault sent in serial-GMII mode");
    a_rf_cause: assert property (!i_remote_fault_cond |=> !o_remote_fault_tx)
        else $error("remote fault sent without cause");
    a_crs_rx: assert property (i_rx_active |=> o_carrier_sense)
        else $error("receive did not raise carrier");
    a_crs_idle: assert property (!i_tx_active && !i_rx_active |=> !o_carrier_sense)
        else $error("carrier without traffic");
    a_limit_map: assert property (o_elastic_limit == (o_elastic_buffer_depth[1] ?
        spc_pkg::LIMIT_13K5 : (o_elastic_buffer_depth[0] ? spc_pkg::LIMIT_10K
        : spc_pkg::LIMIT_5K)))
        else $error("buffer limit does not match depth");
    a_link_drop: assert property (!i_sync_ok |=> !o_link_up)
        else $error("link up without sync");
    // Second read sees nothing when no event came after the first
    a_rd_clear: assert property (s_stat_rd ##0 i_events == 8'h00 ##1
        i_events == 8'h00 ##1 s_stat_rd |=> hrdata[15:8] == 8'h00)
        else $error("latched status not cleared by read");
    // Event in the read's own cycle shows on the next read
    a_ev_kept: assert property (s_stat_rd ##0 i_events.tx_buffer_fault ##2
        s_stat_rd |=> hrdata[15])
        else $error("event in read cycle lost");
endmodule : spc_serdes_regs_monitor
`default_nettype wire

//--- testbench/spc_phy_model.sv
// Far-end PHY model: sync, idles or code words, remote fault
`timescale 1ns/1ps
`default_nettype none
module spc_phy_model (
    // Clock
    input  wire logic       i_core_clk,
    // Stream choice: 0 silent, 1 idles, 2 code words
    input  wire logic [1:0] i_send,
    input  wire logic       i_fault,
    // Line conditions toward the port
    output logic            o_sync_ok,
    output logic            o_rx_idle,
    output logic            o_rx_code_word,
    output logic            o_remote_fault_cond
);
    // Registered like a real receiver; silence loses lock
    always_ff @(posedge i_core_clk)
    begin
        o_sync_ok           <= (i_send != 2'h0);
        o_rx_idle           <= (i_send == 2'h1);
        o_rx_code_word      <= (i_send == 2'h2);
        o_remote_fault_cond <= i_fault;
    end
endmodule : spc_phy_model
`default_nettype wire

//--- testbench/test_spc_serdes_regs.sv
// Self-checking bench for the serial port PCS register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin mismatches++; \
    $display("mismatch %s exp %h got %h", nm, e, g); end end
module test_spc_serdes_regs;
    localparam int unsigned STAB = 20;  // Short qualification keeps the run brief
    localparam logic [31:0] A_C2 = 32'h88, A_C3 = 32'h90, A_RS = 32'h98, A_ST = 32'ha0;
    logic        i_core_clk = 1'h0, i_srst = 1'h1, hsel = 1'h0, hwrite = 1'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, d;
    logic [1:0]  htrans = 2'h0, send = 2'h0, o_elastic_buffer_depth;
    logic [2:0]  hsize = 3'h2;  // Whole words only
    logic        hready, hreadyout, hresp, fault = 1'h0;
    logic        i_sgmii_mode = 1'h0, i_an_enable = 1'h0, i_an_done = 1'h0;
    logic        i_half_duplex = 1'h0, i_crc_check_off = 1'h0;
    logic        i_tx_active = 1'h0, i_rx_active = 1'h0;
    logic        i_sync_ok, i_rx_idle, i_rx_code_word, i_remote_fault_cond;
    logic        o_link_up, o_an_active, o_remote_fault_tx, o_carrier_sense;
    logic [13:0] o_elastic_limit;
    logic [13:0] lim [4] = '{14'h1400, 14'h2800, 14'h3600, 14'h3600};  // Per depth code
    spc_pkg::spc_events_t   i_events = '0;
    spc_pkg::spc_resolved_t i_resolved = '0;
    int          mismatches = 0, samples_checked = 0;

    // Single slave, so its ready is the bus ready
    assign hready = hreadyout;
    always #50 i_core_clk = ~i_core_clk;

    spc_serdes_regs #(.STABLE_CYCLES(STAB)) dut (.i_core_clk, .i_srst, .hsel, .haddr, .htrans,
        .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .i_sgmii_mode,
        .i_an_enable, .i_an_done, .i_half_duplex, .i_crc_check_off, .i_sync_ok, .i_rx_idle,
        .i_rx_code_word, .i_remote_fault_cond, .i_tx_active, .i_rx_active, .i_events,
        .i_resolved, .o_link_up, .o_an_active, .o_remote_fault_tx, .o_carrier_sense,
        .o_elastic_buffer_depth, .o_elastic_limit);
    spc_phy_model phy (.i_core_clk, .i_send(send), .i_fault(fault), .o_sync_ok(i_sync_ok),
        .o_rx_idle(i_rx_idle), .o_rx_code_word(i_rx_code_word),
        .o_remote_fault_cond(i_remote_fault_cond));

    // Verdict and end of run
    task automatic results;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : results

    task automatic tick(input int k);
        repeat (k) @(posedge i_core_clk);
    endtask : tick

    // Next edge with ready high, bounded so a stuck slave ends the run
    task automatic wait_ready;
        int n;
        n = 0;
        @(posedge i_core_clk);
        while (hready !== 1'h1 && n < 64)
        begin
            @(posedge i_core_clk);
            n++;
        end
        if (n >= 64)
        begin
            mismatches++;
            results();
        end
    endtask : wait_ready

    // One single transfer; read data taken at the data-phase edge
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] wd);
        hsel <= 1'h1;
        htrans <= spc_pkg::HTRANS_NONSEQ;
        haddr <= a;
        hwrite <= w;
        wait_ready();
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        d = hrdata;
    endtask : xfer

    task automatic rd_chk(input logic [31:0] a, m, e, input string nm);
        xfer(1'h0, a, 32'h0);
        `CHK(nm, e, d & m)
    endtask : rd_chk

    initial
    begin
        int n;
        tick(20);
        i_srst <= 1'h0;
        tick(3);
        // Reset values, reserved and unmapped places
        rd_chk(A_C2, 32'hffff_ffff, 32'h1, "ctrl2 reset");
        rd_chk(A_C3, 32'hffff_ffff, 32'h42, "ctrl3 reset");
        rd_chk(A_RS, 32'hffff_ffff, 32'h0, "reserved word");
        rd_chk(32'h3fc, 32'hffff_ffff, 32'h0, "unmapped");
        rd_chk(A_ST, 32'hffff_ffff, 32'h0, "status reset");
        `CHK("limit reset", 14'h2800, o_elastic_limit)
        xfer(1'h1, A_C2, 32'hffff_ffff);
        rd_chk(A_C2, 32'hffff_ffff, 32'h17, "ctrl2 mask");
        // Remote fault with sensing off, on, then serial-GMII
        fault <= 1'h1;
        tick(3);
        `CHK("rf sense off", 1'h0, o_remote_fault_tx)
        xfer(1'h1, A_C2, 32'h1);
        tick(3);
        `CHK("rf fiber", 1'h1, o_remote_fault_tx)
        i_sgmii_mode <= 1'h1;
        tick(3);
        `CHK("rf sgmii", 1'h0, o_remote_fault_tx)
        i_sgmii_mode <= 1'h0;
        fault <= 1'h0;
        // Every depth code; reserved bits written as zero
        for (int k = 0; k < 4; k++)
        begin
            xfer(1'h1, A_C3, 32'(k) << 1);
            tick(2);
            `CHK("limit", lim[k], o_elastic_limit)
            `CHK("depth", 2'(k), o_elastic_buffer_depth)
        end
        // Half-duplex carrier with transmit gating on and off
        i_half_duplex <= 1'h1;
        i_tx_active <= 1'h1;
        xfer(1'h1, A_C3, 32'h2002);
        rd_chk(A_C3, 32'hffff_ffff, 32'h2042, "ctrl3 rw");
        tick(3);
        `CHK("crs tx gated", 1'h0, o_carrier_sense)
        i_rx_active <= 1'h1;
        tick(2);
        `CHK("crs rx", 1'h1, o_carrier_sense)
        i_rx_active <= 1'h0;
        xfer(1'h1, A_C3, 32'h2);
        tick(3);
        `CHK("crs tx", 1'h1, o_carrier_sense)
        i_tx_active <= 1'h0;
        // Parallel detect follows the partner's stream
        send <= 2'h2;
        tick(5);
        `CHK("an on words", 1'h1, o_an_active)
        `CHK("no link in an", 1'h0, o_link_up)
        send <= 2'h1;
        tick(5);
        `CHK("an off idles", 1'h0, o_an_active)
        `CHK("link on idles", 1'h1, o_link_up)
        rd_chk(A_ST, 32'h82, 32'h82, "link change");
        rd_chk(A_ST, 32'h80, 32'h0, "change cleared");
        // Stable filter: link only after the hold time
        send <= 2'h0;
        xfer(1'h1, A_C2, 32'h4);
        tick(4);
        send <= 2'h1;
        n = 0;
        while (o_link_up !== 1'h1 && n < 100)
        begin
            @(posedge i_core_clk);
            n++;
        end
        `CHK("filter time", 1'h1, n >= STAB + 1 && n <= STAB + 5)
        // Code words block the link until idles arrive
        send <= 2'h0;
        xfer(1'h1, A_C2, 32'h2);
        tick(4);
        rd_chk(A_ST, 32'h82, 32'h80, "drop before block");
        send <= 2'h2;
        tick(10);
        `CHK("blocked", 1'h0, o_link_up)
        rd_chk(A_ST, 32'h82, 32'h0, "blocked quiet");
        send <= 2'h1;
        tick(5);
        `CHK("unblocked", 1'h1, o_link_up)
        // Each event latches, then clears on read
        xfer(1'h0, A_ST, 32'h0);
        for (int k = 0; k < 8; k++)
        begin
            i_events <= 8'h01 << k;
            tick(1);
            i_events <= 8'h00;
            rd_chk(A_ST, 32'hff00, 32'h100 << k, "event");
            rd_chk(A_ST, 32'hff00, 32'h0, "event clear");
        end
        i_crc_check_off <= 1'h1;
        i_events <= 8'h10;
        tick(1);
        i_events <= 8'h00;
        rd_chk(A_ST, 32'h1000, 32'h0, "crc off");
        // Event during the read's own address cycle survives
        fork
            xfer(1'h0, A_ST, 32'h0);
            begin
                i_events <= 8'h80;
                tick(1);
                i_events <= 8'h00;
            end
        join
        rd_chk(A_ST, 32'h8000, 32'h8000, "event in read");
        // Live pause, speed, duplex and mode bits
        i_sgmii_mode <= 1'h1;
        i_resolved <= 5'h16;
        tick(2);
        rd_chk(A_ST, 32'h7d, 32'h59, "resolved a");
        i_sgmii_mode <= 1'h0;
        i_resolved <= 5'h09;
        tick(2);
        rd_chk(A_ST, 32'h7d, 32'h24, "resolved b");
        results();
    end
endmodule : test_spc_serdes_regs
bind spc_serdes_regs spc_serdes_regs_monitor #(.STABLE_CYCLES(STABLE_CYCLES)) u_mon (
    .i_core_clk, .i_srst, .hsel, .haddr, .htrans, .hwrite, .hready, .hrdata, .hreadyout,
    .hresp, .i_sgmii_mode, .i_remote_fault_cond, .i_sync_ok, .i_tx_active, .i_rx_active,
    .i_events, .o_link_up, .o_remote_fault_tx, .o_carrier_sense, .o_elastic_buffer_depth,
    .o_elastic_limit);
`default_nettype wire
